// [design/sir_pkg.sv]
// constants and types shared by the safety input and reset logic
package sir_pkg;

	localparam int SIR_MS_W = 11;

	////////////////////////////////////////////////////////////////////
	// clock and millisecond enable
	localparam int SIR_CLK_PERIOD_NS = 32'h0000_0005;
	localparam int SIR_MS_NS = 32'h000F_4240;
	localparam int SIR_CYC_PER_MS = SIR_MS_NS / SIR_CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////
	// debounce limits, in ms
	localparam logic [SIR_MS_W-1:0] SIR_HL_MIN_MS = 11'h006;
	localparam logic [SIR_MS_W-1:0] SIR_HL_MAX_MS = 11'h064;
	localparam logic [SIR_MS_W-1:0] SIR_HL_DEF_MS = 11'h006;
	localparam logic [SIR_MS_W-1:0] SIR_LH_MIN_MS = 11'h00A;
	localparam logic [SIR_MS_W-1:0] SIR_LH_MAX_MS = 11'h1F4;
	localparam logic [SIR_MS_W-1:0] SIR_LH_DEF_MS = 11'h032;
	localparam logic [SIR_MS_W-1:0] SIR_MUTE_MAX_MS = 11'h5DC;
	localparam logic [SIR_MS_W-1:0] SIR_FIXED_MS = 11'h032;
	localparam logic [SIR_MS_W-1:0] SIR_QUIET_MS = 11'h003;

	////////////////////////////////////////////////////////////////////
	// reset pulse high time, in ms
	localparam logic [SIR_MS_W-1:0] SIR_RST_MIN_MS = 11'h12C;
	localparam logic [SIR_MS_W-1:0] SIR_RST_MAX_MS = 11'h7D0;

	////////////////////////////////////////////////////////////////////
	// auxiliary lines, placed after the safety lines
	localparam int SIR_N_AUX = 5;
	localparam int SIR_AUX_MRST = 0;
	localparam int SIR_AUX_SRST = 1;
	localparam int SIR_AUX_ONOFF = 2;
	localparam int SIR_AUX_MUTE = 3;
	localparam int SIR_AUX_CANCEL = 4;

	typedef struct packed {
		logic lockout;
		logic fault;
		logic latched;
	} sir_stat_t;

endpackage : sir_pkg

// [design/sir_debounce.sv]
// one-line debounce filter with settle-time limit
`timescale 1ns/100ps
`default_nettype none

module sir_debounce
	import sir_pkg::*;
#(
	parameter logic [SIR_MS_W-1:0] QUIET_MS = SIR_QUIET_MS // quiet time
) (
	input wire logic i_sys_clk, // system clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic i_ms_tick, // one-cycle 1 ms enable
	input wire logic i_raw, // line level, high = Run
	input wire logic [SIR_MS_W-1:0] i_hl_ms, // high-to-low limit
	input wire logic [SIR_MS_W-1:0] i_lh_ms, // low-to-high limit
	output logic o_level, // debounced level
	output logic o_fault // disparity pulse
);

	logic level_r, raw_prev_r, busy_r, fault_r;
	logic [SIR_MS_W-1:0] el_r, qt_r, el_nxt, qt_nxt;

	wire differs = i_raw != level_r;
	wire bounced = i_raw != raw_prev_r;
	wire [SIR_MS_W-1:0] limit = level_r ? i_hl_ms : i_lh_ms;
	wire settle = busy_r && qt_r >= QUIET_MS;
	// too slow to settle: drop to Stop, the safe side
	wire overdue = busy_r && !settle && el_r >= limit;
	wire busy_nxt = (busy_r || differs) && !settle && !overdue;
	wire level_nxt = settle ? i_raw : (overdue ? 1'b0 : level_r);

	assign qt_nxt = (bounced || !busy_nxt) ? '0 :
		qt_r + SIR_MS_W'(i_ms_tick);
	assign el_nxt = !busy_nxt ? '0 : el_r + SIR_MS_W'(i_ms_tick);

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			level_r <= 1'b0;
			raw_prev_r <= 1'b0;
			busy_r <= 1'b0;
			fault_r <= 1'b0;
			el_r <= '0;
			qt_r <= '0;
		end else begin
			level_r <= level_nxt;
			raw_prev_r <= i_raw;
			busy_r <= busy_nxt;
			fault_r <= overdue;
			el_r <= el_nxt;
			qt_r <= qt_nxt;
		end
	end

	assign o_level = level_r;
	assign o_fault = fault_r;

	settle_level_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		$changed(level_r) && !fault_r |-> $past(i_raw) == level_r)
		else $error("level changed to a value the line did not hold");

	fault_stop_a: assert property (
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		busy_r && !settle && el_r >= limit |=> fault_r && !level_r)
		else $error("overdue line not reported and forced to Stop");

endmodule : sir_debounce

`default_nettype wire

// [design/sir_input_reset.sv]
// safety input debounce, reset modes and output permission
`timescale 1ns/100ps
`default_nettype none

module sir_input_reset
	import sir_pkg::*;
#(
	parameter int N_IN = 4, // safety input lines
	parameter int DLY_W = 16, // off-delay width, ms
	parameter int CYC_PER_MS = SIR_CYC_PER_MS // clocks per ms
) (
	input wire logic i_sys_clk, // system clock
	input wire logic i_rst_n, // async reset, active low
	input wire logic [N_IN-1:0] i_safety_raw, // high = Run
	input wire logic [N_IN-1:0] i_ctrl_map, // input controls output
	input wire logic [N_IN-1:0] i_latch_mode, // 1 latch, 0 trip
	input wire logic [N_IN-1:0] i_mute_sensor, // line is mute sensor
	input wire logic i_cfg_default, // use default limits
	input wire logic [SIR_MS_W-1:0] i_hl_ms, // high-to-low limit
	input wire logic [SIR_MS_W-1:0] i_lh_ms, // low-to-high limit
	input wire logic [SIR_MS_W-1:0] i_onoff_hl_ms, // on/off h-l
	input wire logic [SIR_MS_W-1:0] i_onoff_lh_ms, // on/off l-h
	input wire logic i_mrst_raw, // manual reset line
	input wire logic i_system_reset_input_raw, // system reset line
	input wire logic i_onoff_raw, // on/off switch, high = Run
	input wire logic i_mute_en_raw, // mute enable, high = Run
	input wire logic i_cancel_raw, // cancel off-delay line
	input wire logic i_mrst_monitored, // manual reset monitored
	input wire logic i_srst_monitored, // system reset monitored
	input wire logic i_onoff_mapped, // on/off gates the output
	input wire logic i_mute_en_used, // mute enable configured
	input wire logic i_cancel_keep, // 1 keep on, 0 cut off
	input wire logic [DLY_W-1:0] i_off_delay_ms, // 0 = none
	input wire logic i_cfg_change, // configuration altered
	output logic o_safety_out, // safety output, high = on
	output logic [N_IN-1:0] o_run_status, // debounced inputs
	output logic o_onoff_status, // on/off switch status
	output logic o_cancel_ok, // cancel may keep output on
	output logic o_mute_permit, // mute sensors may mute
	output sir_stat_t o_status // lockout, fault, latched
);

	localparam int NL = N_IN + SIR_N_AUX;
	localparam int MS_CW = $clog2(CYC_PER_MS + 1);
	localparam logic [MS_CW-1:0] MS_LAST = MS_CW'(CYC_PER_MS - 1);

	function automatic logic [SIR_MS_W-1:0] clamp_ms(
		input logic [SIR_MS_W-1:0] v,
		input logic [SIR_MS_W-1:0] lo,
		input logic [SIR_MS_W-1:0] hi
	);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp_ms

	////////////////////////////////////////////////////////////////////
	// millisecond enable

	logic [MS_CW-1:0] ms_cnt_r;
	logic ms_tick_r;

	wire ms_wrap = ms_cnt_r == MS_LAST;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ms_cnt_r <= '0;
			ms_tick_r <= 1'b0;
		end else begin
			ms_cnt_r <= ms_wrap ? '0 : ms_cnt_r + 1'b1;
			ms_tick_r <= ms_wrap;
		end
	end

	////////////////////////////////////////////////////////////////////
	// debounce of every line

	logic [NL-1:0] raw_all;
	logic [NL-1:0] level;
	logic [NL-1:0] fault_vec;
	logic [SIR_MS_W-1:0] hl_all [NL];
	logic [SIR_MS_W-1:0] lh_all [NL];

	assign raw_all = {i_cancel_raw, i_mute_en_raw, i_onoff_raw,
		i_system_reset_input_raw, i_mrst_raw, i_safety_raw};

	for (genvar i = 0; i < NL; i++) begin : g_line
		if (i < N_IN) begin : g_safe
			// mute sensors get the wider upper bound
			wire [SIR_MS_W-1:0] hl_hi = i_mute_sensor[i] ?
				SIR_MUTE_MAX_MS : SIR_HL_MAX_MS;
			wire [SIR_MS_W-1:0] lh_hi = i_mute_sensor[i] ?
				SIR_MUTE_MAX_MS : SIR_LH_MAX_MS;
			assign hl_all[i] = i_cfg_default ? SIR_HL_DEF_MS :
				clamp_ms(i_hl_ms, SIR_HL_MIN_MS, hl_hi);
			assign lh_all[i] = i_cfg_default ? SIR_LH_DEF_MS :
				clamp_ms(i_lh_ms, SIR_LH_MIN_MS, lh_hi);
		end else if (i == N_IN + SIR_AUX_ONOFF) begin : g_onoff
			assign hl_all[i] = clamp_ms(i_onoff_hl_ms,
				SIR_HL_MIN_MS, SIR_HL_MAX_MS);
			assign lh_all[i] = clamp_ms(i_onoff_lh_ms,
				SIR_LH_MIN_MS, SIR_LH_MAX_MS);
		end else begin : g_fixed
			assign hl_all[i] = SIR_FIXED_MS;
			assign lh_all[i] = SIR_FIXED_MS;
		end

		sir_debounce u_db (
			.i_sys_clk(i_sys_clk),
			.i_rst_n(i_rst_n),
			.i_ms_tick(ms_tick_r),
			.i_raw(raw_all[i]),
			.i_hl_ms(hl_all[i]),
			.i_lh_ms(lh_all[i]),
			.o_level(level[i]),
			.o_fault(fault_vec[i])
		);
	end

	////////////////////////////////////////////////////////////////////
	// reset pulse checkers: 0 manual, 1 system

	logic mrst_acc, srst_acc;

	for (genvar k = 0; k < 2; k++) begin : g_rchk
		logic prev_r, done_r, acc;
		logic [SIR_MS_W-1:0] cnt_r;
		wire lvl = level[N_IN + k];
		wire mon = (k == 0) ? i_mrst_monitored :
			i_srst_monitored;
		wire sat = &cnt_r;
		// cnt_r still holds the high time on the falling cycle
		wire in_win = cnt_r >= SIR_RST_MIN_MS &&
			cnt_r <= SIR_RST_MAX_MS;
		wire fall = prev_r && !lvl;
		wire [SIR_MS_W-1:0] cnt_nxt = !lvl ? '0 :
			cnt_r + SIR_MS_W'(ms_tick_r && !sat);
		assign acc = mon ? (fall && in_win) :
			(lvl && !done_r && cnt_r >= SIR_RST_MIN_MS);

		always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				prev_r <= 1'b0;
				done_r <= 1'b0;
				cnt_r <= '0;
			end else begin
				prev_r <= lvl;
				done_r <= lvl && (done_r || acc);
				cnt_r <= cnt_nxt;
			end
		end

		mon_window_a: assert property (
			@(posedge i_sys_clk) disable iff (!i_rst_n)
			mon && fall && !in_win |-> !acc)
			else $error("monitored pulse out of window accepted");

		nonmon_once_a: assert property (
			@(posedge i_sys_clk) disable iff (!i_rst_n)
			(acc && !mon) ##1 (lvl && !mon) |-> !acc)
			else $error("non-monitored reset accepted twice");
	end

	assign mrst_acc = g_rchk[0].acc;
	assign srst_acc = g_rchk[1].acc;

	////////////////////////////////////////////////////////////////////
	// output permission

	logic latch_r, lockout_r, fault_r, out_r, keep_r, dly_act_r;
	logic cancel_prev_r, onoff_r, cancel_ok_r, mute_permit_r;
	logic [DLY_W-1:0] dly_cnt_r;

	wire [N_IN-1:0] run_vec = level[N_IN-1:0];
	wire onoff_lvl = level[N_IN + SIR_AUX_ONOFF];
	wire mute_lvl = level[N_IN + SIR_AUX_MUTE];
	wire cancel_lvl = level[N_IN + SIR_AUX_CANCEL];
	wire any_fault = |fault_vec;

	wire mapped_run = &(run_vec | ~i_ctrl_map);
	wire latch_stop = |(~run_vec & i_ctrl_map & i_latch_mode);
	wire onoff_ok = !i_onoff_mapped || onoff_lvl;
	wire on_req = mapped_run && !latch_r && !lockout_r &&
		onoff_ok;
	wire cancel_rise = cancel_lvl && !cancel_prev_r;

	// keep mode: output held while cancel stays active
	wire keep_nxt = !lockout_r && i_cancel_keep && cancel_lvl &&
		(keep_r || (dly_act_r && cancel_rise));
	wire dly_end = dly_act_r && (on_req || keep_nxt ||
		dly_cnt_r >= i_off_delay_ms ||
		(cancel_rise && !i_cancel_keep));
	wire dly_start = out_r && !on_req && !dly_act_r && !keep_r &&
		i_off_delay_ms != '0;
	wire dly_nxt = !lockout_r && (dly_start ||
		(dly_act_r && !dly_end));
	wire [DLY_W-1:0] dly_cnt_nxt = (dly_act_r && !dly_end) ?
		dly_cnt_r + DLY_W'(ms_tick_r) : '0;
	wire out_nxt = !lockout_r && (on_req || dly_nxt || keep_nxt);

	// a Stop arriving with the reset wins over the clear
	wire latch_nxt = latch_stop ||
		(latch_r && !(mrst_acc && mapped_run));
	wire lockout_nxt = any_fault || i_cfg_change ||
		(lockout_r && !srst_acc);
	wire fault_nxt = any_fault || (fault_r && !srst_acc);
	wire mute_nxt = !i_mute_en_used || mute_lvl;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			latch_r <= 1'b0;
			lockout_r <= 1'b0;
			fault_r <= 1'b0;
			out_r <= 1'b0;
			keep_r <= 1'b0;
			dly_act_r <= 1'b0;
			dly_cnt_r <= '0;
			cancel_prev_r <= 1'b0;
			onoff_r <= 1'b0;
			cancel_ok_r <= 1'b0;
			mute_permit_r <= 1'b0;
		end else begin
			latch_r <= latch_nxt;
			lockout_r <= lockout_nxt;
			fault_r <= fault_nxt;
			out_r <= out_nxt;
			keep_r <= keep_nxt;
			dly_act_r <= dly_nxt;
			dly_cnt_r <= dly_cnt_nxt;
			cancel_prev_r <= cancel_lvl;
			onoff_r <= onoff_lvl;
			cancel_ok_r <= dly_nxt && i_cancel_keep;
			mute_permit_r <= mute_nxt;
		end
	end

	assign o_safety_out = out_r;
	assign o_run_status = run_vec;
	assign o_onoff_status = onoff_r;
	assign o_cancel_ok = cancel_ok_r;
	assign o_mute_permit = mute_permit_r;
	assign o_status = '{lockout: lockout_r, fault: fault_r,
		latched: latch_r};

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	stop_forces_off_a: assert property (
		!mapped_run && i_off_delay_ms == '0 && !keep_r && !dly_act_r
		|=> !o_safety_out)
		else $error("output on while an input is in Stop");

	latch_holds_a: assert property (
		latch_r && i_off_delay_ms == '0 && !keep_r && !dly_act_r
		|=> !o_safety_out)
		else $error("latched output turned on without reset");

	trip_return_a: assert property (
		on_req |=> o_safety_out)
		else $error("output not on with all inputs in Run");

	latch_set_a: assert property (
		latch_stop |=> o_status.latched [*1])
		else $error("latch input Stop did not latch");

	reset_ignored_a: assert property (
		latch_r && !mapped_run |=> latch_r)
		else $error("manual reset taken while an input in Stop");

	reset_accept_a: assert property (
		latch_r && mrst_acc && mapped_run |=> !latch_r ##1 1'b1)
		else $error("valid manual reset did not clear latch");

	onoff_gate_a: assert property (
		i_onoff_mapped && !onoff_lvl && i_off_delay_ms == '0 &&
		!keep_r && !dly_act_r |=> !o_safety_out)
		else $error("output on with on/off switch off");

	limit_range_a: assert property (
		hl_all[0] >= SIR_HL_MIN_MS && hl_all[0] <= SIR_MUTE_MAX_MS &&
		lh_all[0] >= SIR_LH_MIN_MS && lh_all[0] <= SIR_MUTE_MAX_MS)
		else $error("debounce limit outside its range");

	mute_gate_a: assert property (
		i_mute_en_used && !mute_lvl |=> !o_mute_permit)
		else $error("mute permitted with mute enable low");

	fault_lock_a: assert property (
		any_fault |=> o_status.lockout && o_status.fault ##1
		(o_status.lockout || $past(srst_acc)))
		else $error("disparity fault did not lock out");

	sysrst_clear_a: assert property (
		lockout_r && srst_acc && !any_fault && !i_cfg_change
		|=> !o_status.lockout)
		else $error("system reset did not clear lockout");

	cancel_cut_a: assert property (
		dly_act_r && cancel_rise && !i_cancel_keep && !on_req
		|=> !o_safety_out)
		else $error("cancel did not cut delayed output");

	cancel_keep_a: assert property (
		o_cancel_ok && cancel_rise && !lockout_r |=> o_safety_out)
		else $error("cancel in window did not keep output on");

endmodule : sir_input_reset

`default_nettype wire

// [verif/sir_field_model.sv]
// field device model: safety lines, reset buttons and switches
`timescale 1ns/100ps
`default_nettype none

module sir_field_model
	import sir_pkg::*;
#(
	parameter int N_IN = 4, // safety lines
	parameter int CPM = 10 // clocks per ms
) (
	input wire logic i_sys_clk, // system clock
	output logic [N_IN+SIR_N_AUX-1:0] o_lines // high = Run or pressed
);
	initial o_lines = '0;

	// lines change just after an edge, like a real contact
	task automatic set(input int idx, input logic val);
		@(posedge i_sys_clk);
		o_lines[idx] <= val;
	endtask : set

	// low-high-low pulse; the hold time decides accept or discard
	task automatic press(input int idx, input int hold_ms);
		set(idx, 1'b1);
		repeat (hold_ms * CPM) @(posedge i_sys_clk);
		o_lines[idx] <= 1'b0;
	endtask : press
endmodule : sir_field_model

`default_nettype wire

// [verif/sir_input_reset_tb_top.sv]
// self-checking bench for the safety input and reset block
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module sir_input_reset_tb_top;
	import sir_pkg::*;
	localparam int N = 4;
	localparam int CPM = 10;
	localparam int MR = N + SIR_AUX_MRST;
	localparam int SR = N + SIR_AUX_SRST;
	localparam int OO = N + SIR_AUX_ONOFF;
	localparam int MU = N + SIR_AUX_MUTE;
	localparam int CA = N + SIR_AUX_CANCEL;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [N-1:0] latch_r = 4'h0;
	logic [N-1:0] ctrl_map = 4'hF;
	logic cfg_def = 1'b1;
	logic [SIR_MS_W-1:0] hl_ms = 11'h064;
	logic srst_mon = 1'b1;
	logic mrst_mon = 1'b1;
	logic onoff_map = 1'b1;
	logic mute_used = 1'b0;
	logic keep = 1'b1;
	logic [15:0] dly = 16'h0000;
	logic cfg_chg = 1'b0;
	wire logic [N+SIR_N_AUX-1:0] lines;
	logic o_safety_out;
	logic [N-1:0] o_run_status;
	logic o_onoff_status;
	logic o_cancel_ok;
	logic o_mute_permit;
	sir_stat_t o_status;
	int error_cnt = 0;
	int compares = 0;

	sir_field_model #(.N_IN(N), .CPM(CPM)) FM (
		.i_sys_clk(i_sys_clk),
		.o_lines(lines)
	);

	sir_input_reset #(.N_IN(N), .DLY_W(16), .CYC_PER_MS(CPM)) DUT (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_safety_raw(lines[N-1:0]),
		.i_ctrl_map(ctrl_map),
		.i_latch_mode(latch_r),
		.i_mute_sensor(4'h0),
		.i_cfg_default(cfg_def),
		.i_hl_ms(hl_ms),
		.i_lh_ms(11'h1F4),
		.i_onoff_hl_ms(11'h006),
		.i_onoff_lh_ms(11'h00A),
		.i_mrst_raw(lines[MR]),
		.i_system_reset_input_raw(lines[SR]),
		.i_onoff_raw(lines[OO]),
		.i_mute_en_raw(lines[MU]),
		.i_cancel_raw(lines[CA]),
		.i_mrst_monitored(mrst_mon),
		.i_srst_monitored(srst_mon),
		.i_onoff_mapped(onoff_map),
		.i_mute_en_used(mute_used),
		.i_cancel_keep(keep),
		.i_off_delay_ms(dly),
		.i_cfg_change(cfg_chg),
		.o_safety_out(o_safety_out),
		.o_run_status(o_run_status),
		.o_onoff_status(o_onoff_status),
		.o_cancel_ok(o_cancel_ok),
		.o_mute_permit(o_mute_permit),
		.o_status(o_status)
	);

	initial begin
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end

	////////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic ms(input int n);
		repeat (n * CPM) @(posedge i_sys_clk);
		#1;
	endtask : ms

	// bounded wait on the output, then compare
	task automatic wait_out(input logic e, input int lim_ms);
		int i;
		i = 0;
		while (o_safety_out !== e && i < lim_ms * CPM) begin
			@(posedge i_sys_clk);
			#1;
			i++;
		end
		`CHK(o_safety_out, e)
	endtask : wait_out

	task automatic stop_test;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_boot;
		`CHK(o_safety_out, 1'b0)
		`CHK(o_status, 3'h0)
		for (int k = 0; k < N; k++) FM.set(k, 1'b1);
		FM.set(OO, 1'b1);
		wait_out(1'b1, 20);
		`CHK(o_run_status, 4'hF)
		`CHK(o_onoff_status, 1'b1)
	endtask : t_boot

	task automatic t_trip;
		FM.set(1, 1'b0);
		wait_out(1'b0, 15);
		FM.set(1, 1'b1);
		wait_out(1'b1, 15);
		// an unmapped line in Stop must not touch the output
		@(posedge i_sys_clk);
		ctrl_map <= 4'hD;
		FM.set(1, 1'b0);
		ms(10);
		`CHK(o_safety_out, 1'b1)
		`CHK(o_run_status, 4'hD)
		FM.set(1, 1'b1);
		ms(10);
		`CHK(o_run_status, 4'hF)
		@(posedge i_sys_clk);
		ctrl_map <= 4'hF;
	endtask : t_trip

	task automatic t_onoff;
		FM.set(OO, 1'b0);
		wait_out(1'b0, 15);
		FM.set(OO, 1'b1);
		wait_out(1'b1, 15);
		@(posedge i_sys_clk);
		onoff_map <= 1'b0;
		FM.set(OO, 1'b0);
		ms(10);
		`CHK(o_safety_out, 1'b1)
		`CHK(o_onoff_status, 1'b0)
	endtask : t_onoff

	task automatic t_mute;
		@(posedge i_sys_clk);
		mute_used <= 1'b1;
		ms(2);
		`CHK(o_mute_permit, 1'b0)
		FM.set(MU, 1'b1);
		ms(10);
		`CHK(o_mute_permit, 1'b1)
	endtask : t_mute

	// 40 ms off-delay: keep-mode cancel outlasts it, cut mode ends it
	task automatic t_cancel;
		`CHK(o_cancel_ok, 1'b0)
		@(posedge i_sys_clk);
		dly <= 16'h0028;
		FM.set(3, 1'b0);
		ms(12);
		`CHK(o_safety_out, 1'b1)
		`CHK(o_cancel_ok, 1'b1)
		FM.set(CA, 1'b1);
		ms(50);
		`CHK(o_safety_out, 1'b1)
		FM.set(CA, 1'b0);
		wait_out(1'b0, 15);
		FM.set(3, 1'b1);
		keep <= 1'b0;
		wait_out(1'b1, 15);
		FM.set(3, 1'b0);
		ms(12);
		`CHK(o_safety_out, 1'b1)
		`CHK(o_cancel_ok, 1'b0)
		FM.set(CA, 1'b1);
		ms(13);
		`CHK(o_safety_out, 1'b0)
		FM.set(CA, 1'b0);
		dly <= 16'h0000;
		FM.set(3, 1'b1);
		wait_out(1'b1, 15);
	endtask : t_cancel

	task automatic t_latch;
		@(posedge i_sys_clk);
		latch_r <= 4'h1;
		FM.set(0, 1'b0);
		wait_out(1'b0, 15);
		FM.press(MR, 400);
		ms(70);
		`CHK(o_status.latched, 1'b1)
		FM.set(0, 1'b1);
		ms(20);
		`CHK(o_safety_out, 1'b0)
		FM.press(MR, 100);
		ms(70);
		`CHK(o_status.latched, 1'b1)
		FM.press(MR, 2100);
		ms(70);
		`CHK(o_status.latched, 1'b1)
		FM.press(MR, 500);
		wait_out(1'b1, 80);
		@(posedge i_sys_clk);
		mrst_mon <= 1'b0;
		FM.set(0, 1'b0);
		wait_out(1'b0, 15);
		FM.set(0, 1'b1);
		ms(20);
		FM.set(MR, 1'b1);
		ms(250);
		`CHK(o_safety_out, 1'b0)
		wait_out(1'b1, 150);
		ms(50);
		`CHK(o_safety_out, 1'b1)
		FM.set(MR, 1'b0);
		mrst_mon <= 1'b1;
		latch_r <= 4'h0;
	endtask : t_latch

	task automatic t_lock;
		@(posedge i_sys_clk);
		cfg_chg <= 1'b1;
		@(posedge i_sys_clk);
		cfg_chg <= 1'b0;
		wait_out(1'b0, 5);
		`CHK(o_status.lockout, 1'b1)
		FM.press(SR, 500);
		wait_out(1'b1, 80);
		`CHK(o_status.lockout, 1'b0)
		// toggling faster than the quiet time never settles
		for (int j = 0; j < 16; j++) begin
			FM.set(2, j[0]);
			repeat (4) @(posedge i_sys_clk);
		end
		ms(5);
		`CHK(o_status, 3'h6)
		`CHK(o_safety_out, 1'b0)
		@(posedge i_sys_clk);
		srst_mon <= 1'b0;
		FM.set(SR, 1'b1);
		ms(250);
		`CHK(o_status.lockout, 1'b1)
		wait_out(1'b1, 80);
		`CHK(o_status, 3'h0)
		FM.set(SR, 1'b0);
		srst_mon <= 1'b1;
		cfg_def <= 1'b0;
		FM.set(2, 1'b0);
		wait_out(1'b0, 15);
		// 60 ms of chatter: past the default, inside the set limit
		for (int j = 1; j < 120; j++) begin
			FM.set(2, j[0]);
			repeat (4) @(posedge i_sys_clk);
		end
		wait_out(1'b1, 15);
		`CHK(o_status.fault, 1'b0)
		@(posedge i_sys_clk);
		cfg_def <= 1'b1;
	endtask : t_lock

	////////////////////////////////////////////////////////////////////
	// main sequence and watchdog
	initial begin
		repeat (8) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		ms(1);
		t_boot();
		t_trip();
		t_onoff();
		t_mute();
		t_cancel();
		t_latch();
		t_lock();
		stop_test();
	end

	initial begin
		repeat (75000) @(posedge i_sys_clk);
		error_cnt++;
		stop_test();
	end
endmodule : sir_input_reset_tb_top

`default_nettype wire
